// ===== shared/vmlsa_pkg.sv
`default_nettype none
// Summary of operation
// - 64-bit OR atomic writes memory OR operand, returns old memory value.
// - 64-bit XOR atomic writes memory XOR operand, returns old memory value.
// - 64-bit increment writes zero when old >= operand, else old plus one; returns old.
// - 64-bit decrement writes operand when old is zero or above it, else old minus one.
// - Float swap takes swap bits 31:0, compare bits 63:32; stores on equality, returns old.
// - Float min stores operand when it compares less than memory; returns old.
// - Float max stores operand when it compares greater than memory; returns old.
// - Float add stores the single-precision sum of operand and memory; returns old.
// - Float min, max and swap compares handle NaN, infinity and denormals.
// - Float add handles NaN, infinity and denormal operands.
// - Private-space instructions treat every lane address as private scratch.
// - Global-space instructions treat every lane address as global memory.
// - Unsigned byte load fills lane bits 7:0, upper 24 bits zero.
// - Unsigned halfword load fills low 16 bits, upper 16 bits zero.
// - Signed byte and halfword loads sign-extend to all 32 lane bits.
// - Multi-dword loads fill successive 32-bit slices from byte offsets 0, 4, 8, 12.
// - Multi-dword stores write successive 32-bit slices to offsets 0, 4, 8, 12.
// - Byte, halfword and dword stores write lane bits 7:0, 15:0 or 31:0.
// - Low-half loads write bits 15:0 and keep bits 31:16.
// - High-half loads write bits 31:16 and keep bits 15:0.
// - High-half stores take the byte from bits 23:16 or halfword from 31:16.
// - Loads to the local share extend as the opcode says and target the share.
// - Generic-space instructions classify each lane address as global, private or share.
package vmlsa_pkg;
	localparam int WORD_W = 32;
	localparam int LANE_W = 128;
	localparam int ADDR_W = 32;
	localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
	localparam logic [1:0] WORD_ALIGN = 2'h0;
	localparam logic [3:0] BE_BYTE0 = 4'h1;
	localparam logic [3:0] BE_HALF_LO = 4'h3;
	localparam logic [3:0] BE_HALF_HI = 4'hc;
	localparam logic [3:0] BE_WORD = 4'hf;
	localparam logic [31:0] F32_QNAN = 32'h7fc0_0000;
	localparam logic [7:0] F32_EXP_ALL = 8'hff;

	typedef enum logic [5:0] {
		OP_LD_U8, OP_LD_I8, OP_LD_U16, OP_LD_I16,
		OP_LD_B32, OP_LD_B64, OP_LD_B96, OP_LD_B128,
		OP_ST_B8, OP_ST_B16, OP_ST_B32, OP_ST_B64, OP_ST_B96, OP_ST_B128,
		OP_LO_U8, OP_LO_I8, OP_LO_B16, OP_HI_U8, OP_HI_I8, OP_HI_B16,
		OP_ST_HI_B8, OP_ST_HI_B16,
		OP_SH_U8, OP_SH_I8, OP_SH_U16, OP_SH_I16, OP_SH_B32,
		OP_AND64, OP_OR64, OP_XOR64, OP_INC64, OP_DEC64,
		OP_FCAS, OP_FMIN, OP_FMAX, OP_FADD
	} vmlsa_op_t;

	typedef enum logic [1:0] {SP_GENERIC, SP_PRIVATE, SP_GLOBAL} vmlsa_space_t;
	typedef enum logic [1:0] {MC_GLOBAL, MC_PRIVATE, MC_SHARE} vmlsa_mclass_t;

	function automatic logic [1:0] op_last(vmlsa_op_t op);
		unique case (op)
			OP_LD_B64, OP_ST_B64, OP_AND64, OP_OR64, OP_XOR64, OP_INC64, OP_DEC64: return 2'h1;
			OP_LD_B96, OP_ST_B96: return 2'h2;
			OP_LD_B128, OP_ST_B128: return 2'h3;
			default: return 2'h0;
		endcase
	endfunction

	function automatic logic op_store(vmlsa_op_t op);
		return op inside {[OP_ST_B8:OP_ST_B128], OP_ST_HI_B8, OP_ST_HI_B16};
	endfunction

	function automatic logic op_atomic(vmlsa_op_t op);
		return op inside {[OP_AND64:OP_FADD]};
	endfunction

	function automatic logic op_share(vmlsa_op_t op);
		return op inside {[OP_SH_U8:OP_SH_B32]};
	endfunction
endpackage
`default_nettype wire

// ===== shared/vmlsa_amo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vmlsa_amo_if;
	import vmlsa_pkg::*;
	vmlsa_op_t   op;
	logic [63:0] old_val;
	logic [63:0] opnd;
	logic [63:0] new_val;
	modport core (output op, output old_val, output opnd, input new_val);
	modport alu (input op, input old_val, input opnd, output new_val);
endinterface
`default_nettype wire

// ===== core/vmlsa_amo_alu.sv
`timescale 1ns/1ps
`default_nettype none
module vmlsa_amo_alu import vmlsa_pkg::*; (
	vmlsa_amo_if.alu amo
);
	function automatic logic f32_nan(logic [31:0] x);
		return x[30:23] == F32_EXP_ALL && x[22:0] != '0;
	endfunction

	// Unordered compares are false; the two zeros are equal
	function automatic logic f32_lt(logic [31:0] a, logic [31:0] b);
		if (f32_nan(a) || f32_nan(b) || (a[30:0] == '0 && b[30:0] == '0))
			return 1'b0;
		if (a[31] != b[31])
			return a[31];
		return a[31] ? (a[30:0] > b[30:0]) : (a[30:0] < b[30:0]);
	endfunction

	function automatic logic f32_eq(logic [31:0] a, logic [31:0] b);
		if (f32_nan(a) || f32_nan(b))
			return 1'b0;
		return a == b || (a[30:0] == '0 && b[30:0] == '0);
	endfunction

	// Round to nearest even, gradual underflow, overflow to infinity
	function automatic logic [31:0] f32_add(logic [31:0] a, logic [31:0] b);
		logic [31:0] x;
		logic [31:0] y;
		logic [27:0] mx;
		logic [27:0] my;
		logic [27:0] s;
		logic [9:0]  ex;
		logic [9:0]  ey;
		logic [9:0]  e;
		logic [24:0] r;
		logic        stk;
		if (f32_nan(a) || f32_nan(b))
			return F32_QNAN;
		if (a[30:23] == F32_EXP_ALL)
			return (b[30:23] == F32_EXP_ALL && a[31] != b[31]) ? F32_QNAN : a;
		if (b[30:23] == F32_EXP_ALL)
			return b;
		{x, y} = (a[30:0] < b[30:0]) ? {b, a} : {a, b};
		ex = (x[30:23] == '0) ? 10'h001 : {2'h0, x[30:23]};
		ey = (y[30:23] == '0) ? 10'h001 : {2'h0, y[30:23]};
		mx = {1'b0, |x[30:23], x[22:0], 3'h0};
		my = {1'b0, |y[30:23], y[22:0], 3'h0};
		stk = 1'b0;
		for (int i = 0; i < 27; i++) begin
			if (10'(i) < ex - ey) begin
				stk = stk | my[0];
				my = my >> 1;
			end
		end
		my[0] = my[0] | stk;
		s = (x[31] == y[31]) ? mx + my : mx - my;
		if (s == '0)
			return {x[31] & y[31], 31'h0000_0000};
		e = ex;
		if (s[27]) begin
			s = {1'b0, s[27:2], s[1] | s[0]};
			e = e + 10'h001;
		end
		for (int i = 0; i < 26; i++) begin
			if (!s[26] && e > 10'h001) begin
				s = s << 1;
				e = e - 10'h001;
			end
		end
		r = {1'b0, s[26:3]} + 25'(s[2] & (s[1] | s[0] | s[3]));
		if (r[24]) begin
			r = r >> 1;
			e = e + 10'h001;
		end
		if (e >= 10'h0ff)
			return {x[31], F32_EXP_ALL, 23'h00_0000};
		return {x[31], r[23] ? e[7:0] : 8'h00, r[22:0]};
	endfunction

	// ----------------------------------------
	// New memory value from old value and operand
	// ----------------------------------------
	always_comb begin
		amo.new_val = amo.old_val;
		unique case (amo.op)
			OP_AND64: amo.new_val = amo.old_val & amo.opnd;
			OP_OR64:  amo.new_val = amo.old_val | amo.opnd;
			OP_XOR64: amo.new_val = amo.old_val ^ amo.opnd;
			OP_INC64: amo.new_val = (amo.old_val >= amo.opnd) ? '0 : amo.old_val + 64'h1;
			OP_DEC64: begin
				if (amo.old_val == '0 || amo.old_val > amo.opnd)
					amo.new_val = amo.opnd;
				else
					amo.new_val = amo.old_val - 64'h1;
			end
			OP_FCAS: if (f32_eq(amo.old_val[31:0], amo.opnd[63:32]))
				amo.new_val[31:0] = amo.opnd[31:0];
			OP_FMIN: if (f32_lt(amo.opnd[31:0], amo.old_val[31:0]))
				amo.new_val[31:0] = amo.opnd[31:0];
			OP_FMAX: if (f32_lt(amo.old_val[31:0], amo.opnd[31:0]))
				amo.new_val[31:0] = amo.opnd[31:0];
			OP_FADD: amo.new_val[31:0] = f32_add(amo.opnd[31:0], amo.old_val[31:0]);
			default: ;
		endcase
	end
endmodule
`default_nettype wire

// ===== core/vmlsa_path.sv
`timescale 1ns/1ps
`default_nettype none
module vmlsa_path import vmlsa_pkg::*; #(
	parameter logic [ADDR_W-1:0] PRIV_BASE   = 32'h0001_0000,
	parameter logic [ADDR_W-1:0] PRIV_LIMIT  = 32'h0001_ffff,
	parameter logic [ADDR_W-1:0] SHARE_BASE  = 32'h0000_0000,
	parameter logic [ADDR_W-1:0] SHARE_LIMIT = 32'h0000_ffff
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              req_valid,
	input  wire vmlsa_op_t         req_op,
	input  wire vmlsa_space_t      req_space,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [LANE_W-1:0] req_lane_data,
	output logic                   req_ready,
	output logic                   mem_req_valid,
	input  wire logic              mem_req_ready,
	output logic                   mem_req_we,
	output logic                   mem_req_lock,
	output vmlsa_mclass_t          mem_req_class,
	output logic [ADDR_W-1:0]      mem_req_addr,
	output logic [3:0]             mem_req_be,
	output logic [WORD_W-1:0]      mem_req_wdata,
	input  wire logic              mem_rsp_valid,
	input  wire logic [WORD_W-1:0] mem_rsp_data,
	output logic                   rsp_valid,
	output logic                   rsp_to_share,
	output logic [LANE_W-1:0]      rsp_data
);
	if (PRIV_BASE > PRIV_LIMIT || SHARE_BASE > SHARE_LIMIT) begin : g_bad_aperture
		$error("aperture base lies above its limit");
	end
	if (PRIV_BASE <= SHARE_LIMIT && SHARE_BASE <= PRIV_LIMIT) begin : g_overlap
		$error("private and share apertures overlap");
	end

	typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WAIT, ST_CALC, ST_WRITE, ST_DONE} vmlsa_state_t;

	vmlsa_state_t      state_reg;
	vmlsa_op_t         op_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [LANE_W-1:0] lane_data_reg;
	logic [LANE_W-1:0] buf_reg;
	logic [63:0]       new_val_reg;
	logic [1:0]        idx_reg;
	logic [1:0]        last_reg;

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic vmlsa_mclass_t classify(vmlsa_space_t sp, logic [ADDR_W-1:0] a);
		unique case (sp)
			SP_PRIVATE: return MC_PRIVATE;
			SP_GLOBAL:  return MC_GLOBAL;
			default: begin
				if (a >= PRIV_BASE && a <= PRIV_LIMIT)
					return MC_PRIVATE;
				if (a >= SHARE_BASE && a <= SHARE_LIMIT)
					return MC_SHARE;
				return MC_GLOBAL;
			end
		endcase
	endfunction

	function automatic logic [3:0] be_of(vmlsa_op_t op, logic [1:0] a);
		unique case (op)
			OP_LD_U8, OP_LD_I8, OP_ST_B8, OP_LO_U8, OP_LO_I8, OP_HI_U8, OP_HI_I8,
			OP_ST_HI_B8, OP_SH_U8, OP_SH_I8:
				return BE_BYTE0 << a;
			OP_LD_U16, OP_LD_I16, OP_ST_B16, OP_LO_B16, OP_HI_B16, OP_ST_HI_B16,
			OP_SH_U16, OP_SH_I16:
				return a[1] ? BE_HALF_HI : BE_HALF_LO;
			default:
				return BE_WORD;
		endcase
	endfunction

	// Narrow store data is replicated on every lane; the byte enables pick one
	function automatic logic [WORD_W-1:0] wr_word(vmlsa_op_t op, logic [LANE_W-1:0] d,
		logic [63:0] nv, logic [1:0] i);
		unique case (op)
			OP_ST_B8:     return {4{d[7:0]}};
			OP_ST_B16:    return {2{d[15:0]}};
			OP_ST_HI_B8:  return {4{d[23:16]}};
			OP_ST_HI_B16: return {2{d[31:16]}};
			OP_ST_B32, OP_ST_B64, OP_ST_B96, OP_ST_B128:
				return d[{i, 5'h00} +: WORD_W];
			default:
				return nv[{i[0], 5'h00} +: WORD_W];
		endcase
	endfunction

	function automatic logic [LANE_W-1:0] result_of(vmlsa_op_t op, logic [LANE_W-1:0] lane,
		logic [LANE_W-1:0] rd, logic [1:0] a);
		logic [WORD_W-1:0] sh;
		logic [7:0]        b;
		logic [15:0]       h;
		sh = rd[WORD_W-1:0] >> {a, 3'h0};
		b = sh[7:0];
		h = sh[15:0];
		result_of = lane;
		unique case (op)
			OP_LD_U8, OP_SH_U8:
				result_of[31:0] = {24'h00_0000, b};
			OP_LD_I8, OP_SH_I8:
				result_of[31:0] = {{24{b[7]}}, b};
			OP_LD_U16, OP_SH_U16:
				result_of[31:0] = {16'h0000, h};
			OP_LD_I16, OP_SH_I16:
				result_of[31:0] = {{16{h[15]}}, h};
			OP_LO_U8:
				result_of[15:0] = {8'h00, b};
			OP_LO_I8:
				result_of[15:0] = {{8{b[7]}}, b};
			OP_LO_B16:
				result_of[15:0] = h;
			OP_HI_U8:
				result_of[31:16] = {8'h00, b};
			OP_HI_I8:
				result_of[31:16] = {{8{b[7]}}, b};
			OP_HI_B16:
				result_of[31:16] = h;
			OP_LD_B32, OP_SH_B32, OP_FCAS, OP_FMIN, OP_FMAX, OP_FADD:
				result_of[31:0] = rd[31:0];
			OP_LD_B64, OP_AND64, OP_OR64, OP_XOR64, OP_INC64, OP_DEC64:
				result_of[63:0] = rd[63:0];
			OP_LD_B96:
				result_of[95:0] = rd[95:0];
			OP_LD_B128:
				result_of = rd;
			default: ;
		endcase
	endfunction

	// ----------------------------------------
	// Atomic arithmetic
	// ----------------------------------------
	vmlsa_amo_if amo ();

	assign amo.op = op_reg;
	assign amo.old_val = buf_reg[63:0];
	assign amo.opnd = lane_data_reg[63:0];

	vmlsa_amo_alu u_alu (
		.amo (amo.alu)
	);

	// ----------------------------------------
	// Memory request sequence
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_LD_U8;
			addr_reg <= '0;
			lane_data_reg <= '0;
			idx_reg <= '0;
			last_reg <= '0;
			req_ready <= 1'b1;
			mem_req_valid <= 1'b0;
			mem_req_we <= 1'b0;
			mem_req_lock <= 1'b0;
			mem_req_class <= MC_GLOBAL;
			mem_req_addr <= '0;
			mem_req_be <= '0;
			mem_req_wdata <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: if (req_valid && req_ready) begin
					req_ready <= 1'b0;
					op_reg <= req_op;
					addr_reg <= req_addr;
					lane_data_reg <= req_lane_data;
					idx_reg <= '0;
					last_reg <= op_last(req_op);
					mem_req_class <= classify(req_space, req_addr);
					mem_req_valid <= 1'b1;
					mem_req_we <= op_store(req_op);
					mem_req_lock <= op_atomic(req_op);
					mem_req_addr <= {req_addr[ADDR_W-1:2], WORD_ALIGN};
					mem_req_be <= be_of(req_op, req_addr[1:0]);
					mem_req_wdata <= wr_word(req_op, req_lane_data, '0, 2'h0);
					state_reg <= op_store(req_op) ? ST_WRITE : ST_READ;
				end
				ST_READ: if (mem_req_ready) begin
					mem_req_valid <= 1'b0;
					state_reg <= ST_WAIT;
				end
				ST_WAIT: if (mem_rsp_valid) begin
					if (idx_reg == last_reg) begin
						idx_reg <= '0;
						state_reg <= op_atomic(op_reg) ? ST_CALC : ST_DONE;
					end else begin
						idx_reg <= idx_reg + 2'h1;
						mem_req_addr <= mem_req_addr + WORD_STEP;
						mem_req_valid <= 1'b1;
						state_reg <= ST_READ;
					end
				end
				ST_CALC: begin
					// Lock stays up from the first read to the last write
					mem_req_addr <= {addr_reg[ADDR_W-1:2], WORD_ALIGN};
					mem_req_we <= 1'b1;
					mem_req_valid <= 1'b1;
					mem_req_wdata <= amo.new_val[WORD_W-1:0];
					state_reg <= ST_WRITE;
				end
				ST_WRITE: if (mem_req_ready) begin
					if (idx_reg == last_reg) begin
						mem_req_valid <= 1'b0;
						mem_req_we <= 1'b0;
						mem_req_lock <= 1'b0;
						state_reg <= ST_DONE;
					end else begin
						idx_reg <= idx_reg + 2'h1;
						mem_req_addr <= mem_req_addr + WORD_STEP;
						mem_req_wdata <= wr_word(op_reg, lane_data_reg, new_val_reg, idx_reg + 2'h1);
					end
				end
				ST_DONE: begin
					idx_reg <= '0;
					req_ready <= 1'b1;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Read capture and lane result
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			buf_reg <= '0;
			new_val_reg <= '0;
			rsp_valid <= 1'b0;
			rsp_to_share <= 1'b0;
			rsp_data <= '0;
		end else begin
			rsp_valid <= state_reg == ST_DONE;
			if (state_reg == ST_WAIT && mem_rsp_valid)
				buf_reg[{idx_reg, 5'h00} +: WORD_W] <= mem_rsp_data;
			if (state_reg == ST_CALC)
				new_val_reg <= amo.new_val;
			if (state_reg == ST_DONE) begin
				rsp_data <= result_of(op_reg, lane_data_reg, buf_reg, addr_reg[1:0]);
				rsp_to_share <= op_share(op_reg);
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_ATOMIC_LOCK: assert property (@(posedge clk) disable iff (sys_rst)
		(mem_req_valid && op_atomic(op_reg)) |-> mem_req_lock)
		else $error("atomic access issued without lock");
	AST_OR_RETURN: assert property (@(posedge clk) disable iff (sys_rst)
		(rsp_valid && op_reg == OP_OR64) |-> rsp_data[63:0] == buf_reg[63:0])
		else $error("or atomic did not return old value");
	AST_XOR_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		(state_reg == ST_CALC && op_reg == OP_XOR64)
		|=> mem_req_wdata == (buf_reg[31:0] ^ lane_data_reg[31:0]))
		else $error("xor atomic wrote wrong value");
	AST_INC_WRAP: assert property (@(posedge clk) disable iff (sys_rst)
		(state_reg == ST_CALC && op_reg == OP_INC64) |=> mem_req_wdata ==
		((buf_reg[63:0] >= lane_data_reg[63:0]) ? 32'h0000_0000 : buf_reg[31:0] + 32'h0000_0001))
		else $error("increment atomic wrote wrong value");
	AST_DEC_WRAP: assert property (@(posedge clk) disable iff (sys_rst)
		(state_reg == ST_CALC && op_reg == OP_DEC64) |=> mem_req_wdata ==
		((buf_reg[63:0] == '0 || buf_reg[63:0] > lane_data_reg[63:0]) ?
		lane_data_reg[31:0] : buf_reg[31:0] - 32'h0000_0001))
		else $error("decrement atomic wrote wrong value");
	AST_FCAS_SWAP: assert property (@(posedge clk) disable iff (sys_rst)
		(state_reg == ST_CALC && op_reg == OP_FCAS && buf_reg[31:0] == lane_data_reg[63:32]
		&& buf_reg[30:23] != F32_EXP_ALL)
		|=> mem_req_valid && mem_req_we && mem_req_wdata == lane_data_reg[31:0])
		else $error("float swap did not store on equality");
	AST_PRIV_SPACE: assert property (@(posedge clk) disable iff (sys_rst)
		(req_valid && req_ready && req_space == SP_PRIVATE) |=> mem_req_class == MC_PRIVATE)
		else $error("private access not classed private");
	AST_GLOBAL_SPACE: assert property (@(posedge clk) disable iff (sys_rst)
		(req_valid && req_ready && req_space == SP_GLOBAL) |=> mem_req_class == MC_GLOBAL)
		else $error("global access not classed global");
	AST_BYTE_ZEXT: assert property (@(posedge clk) disable iff (sys_rst)
		(rsp_valid && op_reg == OP_LD_U8) |-> rsp_data[31:8] == '0)
		else $error("unsigned byte load not zero extended");
	AST_SIGN_EXT: assert property (@(posedge clk) disable iff (sys_rst)
		(rsp_valid && op_reg == OP_LD_I16) |-> rsp_data[31:16] == {16{rsp_data[15]}})
		else $error("signed halfword load not sign extended");
	AST_LO_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
		(rsp_valid && op_reg inside {OP_LO_U8, OP_LO_I8, OP_LO_B16})
		|-> rsp_data[31:16] == lane_data_reg[31:16])
		else $error("low half load disturbed high half");
	AST_HI_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
		(rsp_valid && op_reg inside {OP_HI_U8, OP_HI_I8, OP_HI_B16})
		|-> rsp_data[15:0] == lane_data_reg[15:0])
		else $error("high half load disturbed low half");
endmodule
`default_nettype wire

// ===== bench/vmlsa_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module vmlsa_mem_model import vmlsa_pkg::*; (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              slow,
	input  wire logic              mem_req_valid,
	output logic                   mem_req_ready,
	input  wire logic              mem_req_we,
	input  wire logic              mem_req_lock,
	input  wire vmlsa_mclass_t     mem_req_class,
	input  wire logic [ADDR_W-1:0] mem_req_addr,
	input  wire logic [3:0]        mem_req_be,
	input  wire logic [WORD_W-1:0] mem_req_wdata,
	output logic                   mem_rsp_valid,
	output logic [WORD_W-1:0]      mem_rsp_data
);
	logic [31:0]   mem [int unsigned];
	logic [31:0]   rd_q [$];
	vmlsa_mclass_t last_class;
	logic          last_lock;
	int unsigned   idx;

	// ----------------------------------------
	// Word memory, in-order answers; slow mode halves acceptance and answer rate
	// ----------------------------------------
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_req_ready <= 1'b1;
			mem_rsp_valid <= 1'b0;
			mem_rsp_data <= 32'h0000_0000;
			rd_q.delete();
		end else begin
			mem_req_ready <= slow ? ~mem_req_ready : 1'b1;
			if (rd_q.size() != 0 && (!slow || mem_req_ready)) begin
				mem_rsp_valid <= 1'b1;
				mem_rsp_data <= rd_q.pop_front();
			end else begin
				// Idle data line is scrambled so stale values never look valid
				mem_rsp_valid <= 1'b0;
				mem_rsp_data <= ~mem_rsp_data;
			end
			if (mem_req_valid && mem_req_ready) begin
				idx = mem_req_addr >> 2;
				last_class <= mem_req_class;
				last_lock <= mem_req_lock;
				if (mem_req_we) begin
					for (int b = 0; b < 4; b++) begin
						if (mem_req_be[b])
							mem[idx][8*b+:8] = mem_req_wdata[8*b+:8];
					end
				end else begin
					rd_q.push_back(mem.exists(idx) ? mem[idx] : ~mem_req_addr);
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== bench/tb_vector_memory_load_store_atomic_path.sv
`timescale 1ns/1ps
`default_nettype none
module tb_vector_memory_load_store_atomic_path;
	import vmlsa_pkg::*;
	localparam logic [127:0] LN = 128'hdddd_dddd_cccc_cccc_bbbb_bbbb_aaaa_5555;
	localparam logic [127:0] SL = 128'h4444_4444_3333_3333_2222_2222_1a2b_3c4d;
	localparam logic [31:0]  W  = 32'h8123_45f6;
	logic clk, sys_rst, slow, req_valid, req_ready, mem_req_valid, mem_req_ready, mem_req_we;
	logic mem_rsp_valid, rsp_valid, rsp_to_share, mem_req_lock;
	vmlsa_op_t op_r;
	vmlsa_space_t sp_r;
	vmlsa_mclass_t mem_req_class;
	logic [31:0] addr_r, mem_req_addr, mem_req_wdata, mem_rsp_data;
	logic [127:0] lane_r, rsp_data;
	logic [3:0] mem_req_be;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;

	vmlsa_path u_dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_op(op_r), .req_space(sp_r),
		.req_addr(addr_r), .req_lane_data(lane_r), .req_ready(req_ready), .mem_req_valid(mem_req_valid),
		.mem_req_ready(mem_req_ready), .mem_req_we(mem_req_we), .mem_req_lock(mem_req_lock),
		.mem_req_class(mem_req_class),
		.mem_req_addr(mem_req_addr), .mem_req_be(mem_req_be), .mem_req_wdata(mem_req_wdata),
		.mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data), .rsp_valid(rsp_valid),
		.rsp_to_share(rsp_to_share), .rsp_data(rsp_data));
	vmlsa_mem_model u_mem (.clk(clk), .sys_rst(sys_rst), .slow(slow), .mem_req_valid(mem_req_valid),
		.mem_req_ready(mem_req_ready), .mem_req_we(mem_req_we), .mem_req_lock(mem_req_lock),
		.mem_req_class(mem_req_class),
		.mem_req_addr(mem_req_addr), .mem_req_be(mem_req_be), .mem_req_wdata(mem_req_wdata),
		.mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));

	// ----------------------------------------
	// Common tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic run(input vmlsa_op_t op, input vmlsa_space_t sp, input logic [31:0] a, input logic [127:0] d);
		int n;
		@(posedge clk);
		op_r <= op;
		sp_r <= sp;
		addr_r <= a;
		lane_r <= d;
		req_valid <= 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (rsp_valid !== 1'b1 && n < 300);
		chk("completion", 128'h1, {127'h0, rsp_valid});
	endtask

	function automatic logic [127:0] lw(input logic [31:0] x);
		return {LN[127:32], x};
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic ld(input vmlsa_op_t op, input logic [31:0] a, input logic [127:0] exp, input logic sh);
		for (int i = 0; i < 4; i++)
			u_mem.mem[16+i] = W ^ 32'(i);
		run(op, sh ? SP_PRIVATE : SP_GLOBAL, a, LN);
		chk("load data", exp, sh ? {96'h0, rsp_data[31:0]} : rsp_data);
		chk("share target", {127'h0, sh}, {127'h0, rsp_to_share});
	endtask

	task automatic st(input vmlsa_op_t op, input logic [31:0] a, input logic [127:0] exp);
		for (int i = 0; i < 4; i++)
			u_mem.mem[32+i] = 32'h0000_0000;
		run(op, SP_GLOBAL, a, SL);
		chk("store memory", exp, {u_mem.mem[35], u_mem.mem[34], u_mem.mem[33], u_mem.mem[32]});
		chk("store lane", SL, rsp_data);
	endtask

	task automatic amo(input vmlsa_op_t op, input logic [63:0] old, input logic [63:0] opnd,
		input logic [63:0] exp, input logic w64);
		logic [63:0] m;
		m = w64 ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;
		u_mem.mem[64] = old[31:0];
		u_mem.mem[65] = old[63:32];
		run(op, SP_GLOBAL, 32'h0000_0100, {64'h0, opnd});
		chk("atomic old", {64'h0, old & m}, {64'h0, rsp_data[63:0] & m});
		chk("atomic memory", {64'h0, exp}, {64'h0, u_mem.mem[65], u_mem.mem[64]});
		chk("atomic lock", 128'h1, {127'h0, u_mem.last_lock});
	endtask

	task automatic cls(input vmlsa_space_t sp, input logic [31:0] a, input vmlsa_mclass_t exp);
		run(OP_LD_B32, sp, a, LN);
		chk("address class", {126'h0, exp}, {126'h0, u_mem.last_class});
		chk("read lock", 128'h0, {127'h0, u_mem.last_lock});
	endtask

	task automatic after_reset();
		chk("idle state", 128'h4, {125'h0, req_ready, mem_req_valid, rsp_valid});
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			conclude();
		end
	end

	initial begin
		sys_rst = 1'b1;
		slow = 1'b0;
		req_valid = 1'b0;
		op_r = OP_LD_B32;
		sp_r = SP_GENERIC;
		addr_r = 32'h0000_0000;
		lane_r = 128'h0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		after_reset();
		ld(OP_LD_U8, 32'h0000_0040, lw(32'h0000_00f6), 1'b0);
		ld(OP_LD_I8, 32'h0000_0040, lw(32'hffff_fff6), 1'b0);
		ld(OP_LD_I8, 32'h0000_0041, lw(32'h0000_0045), 1'b0);
		ld(OP_LD_U16, 32'h0000_0042, lw(32'h0000_8123), 1'b0);
		ld(OP_LD_I16, 32'h0000_0042, lw(32'hffff_8123), 1'b0);
		ld(OP_LD_B32, 32'h0000_0040, lw(W), 1'b0);
		ld(OP_LD_B64, 32'h0000_0040, {LN[127:64], W ^ 32'h1, W}, 1'b0);
		ld(OP_LD_B96, 32'h0000_0040, {LN[127:96], W ^ 32'h2, W ^ 32'h1, W}, 1'b0);
		ld(OP_LD_B128, 32'h0000_0040, {W ^ 32'h3, W ^ 32'h2, W ^ 32'h1, W}, 1'b0);
		ld(OP_LO_U8, 32'h0000_0040, lw(32'haaaa_00f6), 1'b0);
		ld(OP_LO_I8, 32'h0000_0040, lw(32'haaaa_fff6), 1'b0);
		ld(OP_LO_B16, 32'h0000_0042, lw(32'haaaa_8123), 1'b0);
		ld(OP_HI_U8, 32'h0000_0043, lw(32'h0081_5555), 1'b0);
		ld(OP_HI_I8, 32'h0000_0040, lw(32'hfff6_5555), 1'b0);
		ld(OP_HI_B16, 32'h0000_0040, lw(32'h45f6_5555), 1'b0);
		ld(OP_SH_I8, 32'h0000_0040, 128'hffff_fff6, 1'b1);
		ld(OP_SH_U8, 32'h0000_0041, 128'h0000_0045, 1'b1);
		ld(OP_SH_I16, 32'h0000_0042, 128'hffff_8123, 1'b1);
		ld(OP_SH_U16, 32'h0000_0042, 128'h0000_8123, 1'b1);
		ld(OP_SH_B32, 32'h0000_0040, {96'h0, W}, 1'b1);
		slow <= 1'b1;
		st(OP_ST_B8, 32'h0000_0081, 128'h0000_4d00);
		st(OP_ST_B16, 32'h0000_0082, 128'h3c4d_0000);
		st(OP_ST_B32, 32'h0000_0080, 128'h1a2b_3c4d);
		st(OP_ST_HI_B8, 32'h0000_0083, 128'h2b00_0000);
		st(OP_ST_HI_B16, 32'h0000_0080, 128'h0000_1a2b);
		st(OP_ST_B64, 32'h0000_0080, {64'h0, SL[63:0]});
		st(OP_ST_B96, 32'h0000_0080, {32'h0, SL[95:0]});
		st(OP_ST_B128, 32'h0000_0080, SL);
		amo(OP_AND64, 64'hffff_0000_1234_5678, 64'h0f0f_ffff_ffff_0000, 64'h0f0f_0000_1234_0000, 1'b1);
		amo(OP_OR64, 64'h0f0f_0000_0000_00f0, 64'h00f0_0000_8000_0001, 64'h0fff_0000_8000_00f1, 1'b1);
		amo(OP_XOR64, 64'hffff_0000_1234_5678, 64'h0f0f_0000_ffff_0000, 64'hf0f0_0000_edcb_5678, 1'b1);
		amo(OP_INC64, 64'h5, 64'h5, 64'h0, 1'b1);
		amo(OP_INC64, 64'hffff_ffff, 64'h1_0000_0000, 64'h1_0000_0000, 1'b1);
		amo(OP_DEC64, 64'h0, 64'h9, 64'h9, 1'b1);
		amo(OP_DEC64, 64'ha, 64'h9, 64'h9, 1'b1);
		amo(OP_DEC64, 64'h1_0000_0000, 64'h2_0000_0000, 64'hffff_ffff, 1'b1);
		amo(OP_FCAS, 64'h3f80_0000, 64'h3f80_0000_4040_0000, 64'h4040_0000, 1'b0);
		amo(OP_FCAS, 64'h7fc0_0000, 64'h7fc0_0000_4040_0000, 64'h7fc0_0000, 1'b0);
		amo(OP_FCAS, 64'h0, 64'h8000_0000_3f80_0000, 64'h3f80_0000, 1'b0);
		amo(OP_FMIN, 64'h3f80_0000, 64'h3f00_0000, 64'h3f00_0000, 1'b0);
		amo(OP_FMIN, 64'h3f80_0000, 64'h7fc0_0000, 64'h3f80_0000, 1'b0);
		amo(OP_FMIN, 64'h2, 64'h1, 64'h1, 1'b0);
		amo(OP_FMAX, 64'h3f80_0000, 64'h4000_0000, 64'h4000_0000, 1'b0);
		amo(OP_FMAX, 64'h3f80_0000, 64'hff80_0000, 64'h3f80_0000, 1'b0);
		amo(OP_FADD, 64'h3f80_0000, 64'h4000_0000, 64'h4040_0000, 1'b0);
		amo(OP_FADD, 64'h7f80_0000, 64'hff80_0000, {32'h0, F32_QNAN}, 1'b0);
		amo(OP_FADD, 64'h1, 64'h1, 64'h2, 1'b0);
		slow <= 1'b0;
		cls(SP_PRIVATE, 32'h0003_0000, MC_PRIVATE);
		cls(SP_GLOBAL, 32'h0000_0100, MC_GLOBAL);
		cls(SP_GENERIC, 32'h0000_0100, MC_SHARE);
		cls(SP_GENERIC, 32'h0001_0010, MC_PRIVATE);
		cls(SP_GENERIC, 32'h0003_0000, MC_GLOBAL);
		conclude();
	end
endmodule
`default_nettype wire
